// ==== design/video_dac_pkg.sv ====
// constants shared by the triple video converter input stage
package video_dac_pkg;
    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int CODE_W = 8;                       // bits per colour channel
    localparam logic [CODE_W-1:0] CODE_WHITE = 8'hFF; // forced full-scale code
    localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;  // zero code
    // ----------------------------------------------------------------
    // reset values of the pipeline
    // ----------------------------------------------------------------
    localparam logic RST_BLANK_ACTIVE = 1'b1;  // outputs blanked after reset
    localparam logic RST_SYNC_ACTIVE = 1'b0;   // sync source on after reset
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;               // system clock rate
    localparam int MAX_PIXEL_MHZ = 30;         // highest supported pixel rate
    // output level selected for a pixel
    typedef enum logic [2:0] {
        LVL_BLANK,
        LVL_WHITE,
        LVL_DATA
    } level_t;
endpackage

// ==== design/video_dac_input.sv ====
// input pipeline of a triple 8-bit video converter
// What this block does
// - capture 24-bit colour word every rising edge
// - force-white drives all codes to all ones
// - controls captured on same edge as colour
// - blank low forces blanking, ignores data, white
// - sync low switches off green timing current
// - channel codes binary, bit 0 least significant
// - white level with force-white, no control asserted
// - green carries black offset unless blank low
// - accept a new pixel every clock
`timescale 1ns/1ps
module video_dac_input
    import video_dac_pkg::*;
(
    // clock and synchronous reset
    input wire logic clk,
    input wire logic rst,
    // one pixel per clock from the controller, plain binary
    input wire logic [CODE_W-1:0] red_code,
    input wire logic [CODE_W-1:0] green_code,
    input wire logic [CODE_W-1:0] blue_code,
    // controls, captured with the pixel they belong to
    input wire logic force_white,
    input wire logic blank_n,
    input wire logic sync_n,
    // codes applied to the three converters
    output logic [CODE_W-1:0] red_current_out,
    output logic [CODE_W-1:0] green_current_out,
    output logic [CODE_W-1:0] blue_current_out,
    // black offset switches, one per channel
    output logic red_black_offset_on,
    output logic green_black_offset_on,
    output logic blue_black_offset_on,
    // sync current source switch for the green timing output
    output logic green_timing_current_out
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        // stage one: pixel and controls as captured
        logic [CODE_W-1:0] red;     // captured red code
        logic [CODE_W-1:0] green;   // captured green code
        logic [CODE_W-1:0] blue;    // captured blue code
        logic white;                // captured force-white
        logic blank_n;              // captured blank, active low
        logic sync_n;               // captured sync, active low
        // stage two: what the converters are driven with
        level_t level;              // selected level
        logic [CODE_W-1:0] red_o;   // red converter code
        logic [CODE_W-1:0] green_o; // green converter code
        logic [CODE_W-1:0] blue_o;  // blue converter code
        logic offset_on;            // black offset enabled on all channels
        logic timing_on;            // sync current source on
    } state_t;

    state_t state_reg; // registered state
    state_t state_next; // next state

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    // stage one captures; stage two selects the level
    always_comb
    begin
        state_next = state_reg;
        // capture colour and controls together, new pixel each clock
        state_next.red = red_code;
        state_next.green = green_code;
        state_next.blue = blue_code;
        state_next.white = force_white;
        state_next.blank_n = blank_n;
        state_next.sync_n = sync_n;
        // level selection on captured values, one stage later
        if (!state_reg.blank_n)
        begin
            // blanking: codes and white ignored
            state_next.level = LVL_BLANK;
            state_next.red_o = CODE_ZERO;
            state_next.green_o = CODE_ZERO;
            state_next.blue_o = CODE_ZERO;
            state_next.offset_on = 1'b0;
        end
        else if (state_reg.white)
        begin
            // white: full scale plus black offset
            state_next.level = LVL_WHITE;
            state_next.red_o = CODE_WHITE;
            state_next.green_o = CODE_WHITE;
            state_next.blue_o = CODE_WHITE;
            state_next.offset_on = 1'b1;
        end
        else
        begin
            // normal pixel: data plus black offset
            state_next.level = LVL_DATA;
            state_next.red_o = state_reg.red;
            state_next.green_o = state_reg.green;
            state_next.blue_o = state_reg.blue;
            state_next.offset_on = 1'b1;
        end
        // sync only removes the timing current, never overrides others
        state_next.timing_on = state_reg.sync_n;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // synchronous reset puts outputs at the blanking level
    always_ff @(posedge clk)
    begin
        // a reset edge drops the pixel that it would have captured
        if (rst)
        begin
            state_reg <= '0;
            state_reg.blank_n <= ~RST_BLANK_ACTIVE;
            state_reg.sync_n <= ~RST_SYNC_ACTIVE;
            state_reg.level <= LVL_BLANK;
            state_reg.timing_on <= ~RST_SYNC_ACTIVE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flip-flops
    // the three offset switches share one flip-flop, copied per channel
    assign red_current_out = state_reg.red_o;
    assign green_current_out = state_reg.green_o;
    assign blue_current_out = state_reg.blue_o;
    assign red_black_offset_on = state_reg.offset_on;
    assign green_black_offset_on = state_reg.offset_on;
    assign blue_black_offset_on = state_reg.offset_on;
    assign green_timing_current_out = state_reg.timing_on;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    // pixel checks start only on an edge that captured, not on a reset edge,
    // and need no reset at the two edges that carry the pixel through

    // red code reaches its converter two edges after it is driven
    a_capture_red: assert property (@(posedge clk) disable iff (rst)
        !rst && blank_n && !force_white ##2 1'b1 |-> red_current_out == $past(red_code, 2))
        else $error("red code not passed after two edges");

    // green code keeps its bit order through the pipe
    a_capture_green: assert property (@(posedge clk) disable iff (rst)
        !rst && blank_n && !force_white ##2 1'b1 |-> green_current_out == $past(green_code, 2))
        else $error("green code not passed in order");

    // blue code reaches its converter two edges after it is driven
    a_capture_blue: assert property (@(posedge clk) disable iff (rst)
        !rst && blank_n && !force_white ##2 1'b1 |-> blue_current_out == $past(blue_code, 2))
        else $error("blue code not passed after two edges");

    // force-white puts all ones on blue
    a_white_forced: assert property (@(posedge clk) disable iff (rst)
        !rst && force_white && blank_n |-> ##2 blue_current_out == CODE_WHITE)
        else $error("force white did not give all ones");

    // force-white puts all ones on red and green too
    a_white_all: assert property (@(posedge clk) disable iff (rst)
        !rst && force_white && blank_n |-> ##2
        (red_current_out == CODE_WHITE && green_current_out == CODE_WHITE))
        else $error("force white missed a channel");

    // blanking clears red code and green offset
    a_blank_wins: assert property (@(posedge clk) disable iff (rst)
        !rst && !blank_n |-> ##2 (red_current_out == CODE_ZERO && !green_black_offset_on))
        else $error("blank did not force blanking level");

    // blanking clears the other codes and offsets
    a_blank_codes: assert property (@(posedge clk) disable iff (rst)
        !rst && !blank_n |-> ##2 (green_current_out == CODE_ZERO &&
        blue_current_out == CODE_ZERO && !red_black_offset_on && !blue_black_offset_on))
        else $error("blank left a code or offset on");

    // sync low removes the timing current
    a_sync_off: assert property (@(posedge clk) disable iff (rst)
        !rst && !sync_n |-> ##2 !green_timing_current_out)
        else $error("sync current not switched off");

    // sync high keeps the timing current
    a_sync_on: assert property (@(posedge clk) disable iff (rst)
        !rst && sync_n |-> ##2 green_timing_current_out)
        else $error("sync current missing while sync high");

    // sync inside blanking leaves green with no current at all
    a_sync_level: assert property (@(posedge clk) disable iff (rst)
        !rst && !blank_n && !sync_n |-> ##2
        (!green_timing_current_out && !green_black_offset_on))
        else $error("sync level not reached");

    // sync travels with the same delay as the pixel
    a_sync_aligned: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) |-> green_timing_current_out == $past(sync_n, 2))
        else $error("sync not aligned with data");

    // white level: full green code, red offset and sync current
    a_white_level: assert property (@(posedge clk) disable iff (rst)
        !rst && force_white && blank_n && sync_n |-> ##2
        (green_current_out == CODE_WHITE && green_timing_current_out && red_black_offset_on))
        else $error("white level incomplete");

    // normal pixel carries the black offset on blue
    a_data_offset: assert property (@(posedge clk) disable iff (rst)
        !rst && blank_n |-> ##2 blue_black_offset_on)
        else $error("black offset missing on pixel");

    // normal pixel carries the black offset on red and green
    a_offsets_on: assert property (@(posedge clk) disable iff (rst)
        !rst && blank_n |-> ##2 (red_black_offset_on && green_black_offset_on))
        else $error("black offset missing on red or green");

    // blank reaches the offsets with the same delay as the data
    a_latency_same: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && $past(blank_n, 2) |-> red_black_offset_on)
        else $error("control latency differs from data");

    // a reset edge leaves the outputs at the blanking level with sync on
    a_reset_blank: assert property (@(posedge clk)
        rst |=> (red_current_out == CODE_ZERO && green_current_out == CODE_ZERO &&
        blue_current_out == CODE_ZERO && !green_black_offset_on && green_timing_current_out))
        else $error("reset did not leave the blanking level");
endmodule

// ==== bench/pixel_source.sv ====
// graphics controller model that drives one pixel per clock
`timescale 1ns/1ps
module pixel_source
    import video_dac_pkg::*;
(
    input wire logic clk,
    output logic [CODE_W-1:0] red_code,
    output logic [CODE_W-1:0] green_code,
    output logic [CODE_W-1:0] blue_code,
    output logic force_white,
    output logic blank_n,
    output logic sync_n
);
    // idle pixel at time zero: black, no controls asserted
    initial
    begin
        {red_code, green_code, blue_code} = 24'h000000;
        {force_white, blank_n, sync_n} = 3'h3;
    end
    // new pixel launched just after every edge, back to back
    task automatic send(input logic [CODE_W-1:0] r, g, b, input logic w, bl, sy);
        @(posedge clk);
        red_code <= r; // plain binary, bit 0 lsb
        green_code <= g;
        blue_code <= b;
        force_white <= w;
        blank_n <= bl;
        sync_n <= bl ? 1'h1 : sy; // sync pulse only inside blanking
    endtask
endmodule

// ==== bench/tb.sv ====
// self-checking bench for the converter input pipeline
`timescale 1ns/1ps
module tb
    import video_dac_pkg::*;
;
    // ----------------------------------------------------------------
    // clock, reset, design and controller model
    // ----------------------------------------------------------------
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic watch = 1'h0; // comparisons armed once reset has filled the pipe
    int fails = 0;
    int checks_done = 0;
    logic [CODE_W-1:0] r, g, b;
    logic [CODE_W-1:0] rs, gs, bs; // converter codes seen
    logic w, bl, sy, ro, go, bo, ts;
    logic [27:0] exp1, exp2; // expected outputs, two stages deep
    logic [27:0] seen; // all outputs in the order of the expected word
    localparam logic [27:0] EXP_RESET = {{3{CODE_ZERO}}, 3'h0, 1'h1}; // blank, sync current on
    always #20 clk = ~clk;
    pixel_source src (.clk(clk), .red_code(r), .green_code(g), .blue_code(b),
        .force_white(w), .blank_n(bl), .sync_n(sy));
    video_dac_input DUT (.clk(clk), .rst(rst), .red_code(r), .green_code(g),
        .blue_code(b), .force_white(w), .blank_n(bl), .sync_n(sy),
        .red_current_out(rs), .green_current_out(gs), .blue_current_out(bs),
        .red_black_offset_on(ro), .green_black_offset_on(go),
        .blue_black_offset_on(bo), .green_timing_current_out(ts));
    // level chosen for one pixel: blank over white over data
    function automatic logic [27:0] level(input logic [23:0] c, input logic w, bl, sy);
        if (!bl) return {24'h000000, 3'h0, sy};
        if (w) return {{3{CODE_WHITE}}, 3'h7, sy};
        return {c, 3'h7, sy};
    endfunction
    // expected pipeline, one stage per edge after capture
    always @(posedge clk)
    begin
        exp1 <= rst ? EXP_RESET : level({r, g, b}, w, bl, sy);
        exp2 <= rst ? EXP_RESET : exp1; // a reset edge blanks the outputs at once
    end
    task automatic check(input string what, input logic [27:0] e, input logic [27:0] s);
        checks_done++;
        if (s !== e)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    // outputs compared mid-cycle, where they are settled
    assign seen = {rs, gs, bs, ro, go, bo, ts};
    always @(negedge clk)
        if (watch) check("outputs", exp2, seen);
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_data(); // walking ones per channel, back to back
        for (int i = 0; i < 8; i++)
            src.send(8'h01 << i, 8'h80 >> i, 8'h01 << i, 1'h0, 1'h1, 1'h1);
        src.send(8'hFF, 8'h00, 8'h5A, 1'h0, 1'h1, 1'h1);
        repeat (3) @(posedge clk);
        $display("test_data done, fails %0d", fails);
    endtask
    task automatic test_white(); // force-white over varied data
        src.send(8'h12, 8'h00, 8'hA5, 1'h1, 1'h1, 1'h1);
        src.send(8'h12, 8'h00, 8'hA5, 1'h0, 1'h1, 1'h1);
        src.send(8'hFF, 8'hFF, 8'hFF, 1'h0, 1'h1, 1'h1);
        src.send(8'h00, 8'h00, 8'h00, 1'h1, 1'h1, 1'h1);
        repeat (3) @(posedge clk);
        $display("test_white done, fails %0d", fails);
    endtask
    task automatic test_blank(); // blanking with and without sync and white
        for (int i = 0; i < 4; i++)
            src.send(8'hC3, 8'h3C, 8'h99, i[0], 1'h0, i[1]);
        src.send(8'h00, 8'h00, 8'h00, 1'h0, 1'h1, 1'h1);
        repeat (3) @(posedge clk);
        $display("test_blank done, fails %0d", fails);
    endtask
    task automatic test_reset(); // reset in mid stream blanks the outputs
        src.send(8'h77, 8'h66, 8'h55, 1'h0, 1'h1, 1'h1);
        rst <= 1'h1;
        src.send(8'h44, 8'h33, 8'h22, 1'h1, 1'h1, 1'h1);
        src.send(8'h44, 8'h33, 8'h22, 1'h0, 1'h1, 1'h1);
        rst <= 1'h0;
        repeat (3) src.send(8'h11, 8'h22, 8'h33, 1'h0, 1'h1, 1'h1);
        repeat (3) @(posedge clk);
        $display("test_reset done, fails %0d", fails);
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        watch = 1'h1;
        test_data();
        test_white();
        test_blank();
        test_reset();
        report_and_stop();
    end
    // watchdog, far beyond the few dozen cycles the tests take
    initial
    begin
        #40000;
        fails++;
        report_and_stop();
    end
endmodule
